/* rtl/irq_pkg.sv */
// Constants, register map and state encodings of the interrupt controller.
// Assumes a 125 MHz REF_CLK and an instruction cycle of four clocks.
package irq_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PC_W   = 13;
    localparam int unsigned SOURCE_COUNT = 10;

    // Byte offsets on the APB.
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_PFLAG   = 8'h04;
    localparam logic [7:0] OFF_PEN     = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0C;
    localparam logic [7:0] OFF_CLEAR   = 8'h10;
    localparam logic [7:0] OFF_ENABLE  = 8'h14;

    // Field positions of irq_control_reg.
    localparam int unsigned GLOBAL_EN_BIT = 7;
    localparam int unsigned T0_EN_BIT     = 5;
    localparam int unsigned EXT_EN_BIT    = 4;
    localparam int unsigned PB_EN_BIT     = 3;
    localparam int unsigned T0_FLAG_BIT   = 2;
    localparam int unsigned EXT_FLAG_BIT  = 1;
    localparam int unsigned PB_FLAG_BIT   = 0;

    // Field positions shared by peripheral_flag_reg and peripheral_enable_reg.
    localparam int unsigned NVM_BIT = 7;
    localparam int unsigned CMP_BIT = 6;
    localparam int unsigned RX_BIT  = 5;
    localparam int unsigned TX_BIT  = 4;
    localparam int unsigned CCP_BIT = 2;
    localparam int unsigned T2_BIT  = 1;
    localparam int unsigned T1_BIT  = 0;

    // Implemented bits; the others read as zero.
    localparam logic [7:0] CONTROL_MASK = 8'hBF;
    localparam logic [7:0] PERIPH_MASK  = 8'hF7;

    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] PFLAG_RST   = 8'h00;
    localparam logic [7:0] PEN_RST     = 8'h00;

    localparam logic [12:0] IRQ_VECTOR = 13'h0004;

    // Clock phases within one instruction cycle.
    localparam logic [1:0] PHASE_SAMPLE = 2'h0;
    localparam logic [1:0] PHASE_LAST   = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_FLUSH  = 2'b01,
        ST_VECTOR = 2'b10,
        ST_ABORT  = 2'b11
    } vec_state_t;

endpackage

/* rtl/mcu_interrupt_controller.sv */
// Interrupt controller of a small 8-bit microcontroller, with APB registers.
// Assumes all inputs are synchronous to REF_CLK and that the core steps one
// instruction per four REF_CLK cycles, aligned to CYCLE_END.
`timescale 1ns/100ps
module mcu_interrupt_controller (
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        EXTERNAL_IRQ_PIN,
    input  wire logic [3:0]  PORT_B_UPPER_NIBBLE,
    input  wire logic        TIMER_ZERO_OVF,
    input  wire logic        TIMER_ONE_OVF,
    input  wire logic        TIMER_TWO_MATCH,
    input  wire logic        CMP_EVT,
    input  wire logic        TX_EVT,
    input  wire logic        RX_EVT,
    input  wire logic        CCP_EVT,
    input  wire logic        NVM_EVT,
    input  wire logic        RETURN_FROM_IRQ_INSTR,
    input  wire logic [12:0] RETURN_PC,
    output logic             CYCLE_END,
    output logic             IRQ_REQ,
    output logic             GLOBAL_IRQ_ENABLE,
    output logic             CORE_NOP,
    output logic             STACK_PUSH,
    output logic      [12:0] STACK_PUSH_DATA,
    output logic             PC_LOAD,
    output logic      [12:0] PC_LOAD_VALUE
);

    typedef struct packed {
        logic [1:0]         phase;
        irq_pkg::vec_state_t state;
        logic [7:0]         ctl;
        logic [7:0]         pflag;
        logic [7:0]         pen;
        logic               cyc_end;
        logic               irq_req;
        logic               nop;
        logic               push;
        logic [12:0]        push_pc;
        logic [12:0]        load_pc;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
    } ctl_state_t;

    ctl_state_t st_reg;
    ctl_state_t st_next;

    logic       last;
    logic       sample;
    logic       apb_setup;
    logic       apb_wr;
    logic       pending;
    logic [0:0] ext_rise;
    logic [3:0] pb_change;
    logic [7:0] ctl_events;
    logic [7:0] pflag_events;
    logic [15:0] flags_view;
    logic [15:0] en_view;

    assign last   = st_reg.phase == irq_pkg::PHASE_LAST;
    assign sample = st_reg.phase == irq_pkg::PHASE_SAMPLE;

    // Pins are looked at once per instruction cycle; an edge that misses the
    // sample phase waits up to three clocks, which makes the latency 12 to 15 clocks.
    pin_event_sampler #(
        .WIDTH (1)
    ) u_ext_sampler (
        .clk    (REF_CLK),
        .rst    (RST),
        .sample (sample),
        .pins   (EXTERNAL_IRQ_PIN),
        .rise   (ext_rise),
        .change ()
    );

    pin_event_sampler #(
        .WIDTH (4)
    ) u_pb_sampler (
        .clk    (REF_CLK),
        .rst    (RST),
        .sample (sample),
        .pins   (PORT_B_UPPER_NIBBLE),
        .rise   (),
        .change (pb_change)
    );

    always_comb begin
        st_next = st_reg;

        st_next.phase   = st_reg.phase + 2'h1;
        st_next.cyc_end = st_reg.phase == (irq_pkg::PHASE_LAST - 2'h1);
        st_next.push    = 1'b0;

        ctl_events = '0;
        ctl_events[irq_pkg::T0_FLAG_BIT]  = TIMER_ZERO_OVF;
        ctl_events[irq_pkg::EXT_FLAG_BIT] = ext_rise[0];
        ctl_events[irq_pkg::PB_FLAG_BIT]  = |pb_change;

        pflag_events = '0;
        pflag_events[irq_pkg::NVM_BIT] = NVM_EVT;
        pflag_events[irq_pkg::CMP_BIT] = CMP_EVT;
        pflag_events[irq_pkg::RX_BIT]  = RX_EVT;
        pflag_events[irq_pkg::TX_BIT]  = TX_EVT;
        pflag_events[irq_pkg::CCP_BIT] = CCP_EVT;
        pflag_events[irq_pkg::T2_BIT]  = TIMER_TWO_MATCH;
        pflag_events[irq_pkg::T1_BIT]  = TIMER_ONE_OVF;

        flags_view = {st_reg.pflag, 5'h00, st_reg.ctl[2:0]};
        en_view    = {st_reg.pen, 5'h00, st_reg.ctl[5:3]};
        pending    = |(flags_view & en_view);

        apb_setup    = PSEL & ~PENABLE;
        // A write lands only in the access cycle that this block acknowledges,
        // so a master that stretches its access phase cannot write twice.
        apb_wr       = PSEL & PENABLE & PWRITE & st_reg.pready;

        if (apb_wr) begin
            case (PADDR)
                irq_pkg::OFF_CONTROL: begin
                    st_next.ctl = PWDATA[7:0] & irq_pkg::CONTROL_MASK;
                end
                irq_pkg::OFF_PFLAG: begin
                    st_next.pflag = PWDATA[7:0] & irq_pkg::PERIPH_MASK;
                end
                irq_pkg::OFF_PEN: begin
                    st_next.pen = PWDATA[7:0] & irq_pkg::PERIPH_MASK;
                end
                irq_pkg::OFF_CLEAR: begin
                    st_next.ctl[2:0] = st_reg.ctl[2:0] & ~PWDATA[2:0];
                    st_next.pflag    = st_reg.pflag & ~PWDATA[15:8];
                end
                irq_pkg::OFF_ENABLE: begin
                    st_next.ctl[5:3] = PWDATA[2:0];
                    st_next.pen      = PWDATA[15:8] & irq_pkg::PERIPH_MASK;
                end
                default: begin
                    st_next.ctl = st_reg.ctl;
                end
            endcase
        end

        // Events are ORed in last so that a set in the clearing cycle wins,
        // and they land whatever any enable says.
        st_next.ctl[2:0] = st_next.ctl[2:0] | ctl_events[2:0];
        st_next.pflag    = st_next.pflag | (pflag_events & irq_pkg::PERIPH_MASK);

        st_next.irq_req = st_reg.ctl[irq_pkg::GLOBAL_EN_BIT] & pending;

        if (last) begin
            case (st_reg.state)
                irq_pkg::ST_IDLE: begin
                    if (st_reg.ctl[irq_pkg::GLOBAL_EN_BIT] && pending) begin
                        st_next.state = irq_pkg::ST_FLUSH;
                    end
                end
                irq_pkg::ST_FLUSH: begin
                    // The instruction in this cycle cleared the enable, so the
                    // entry is dropped and the flags stay pending.
                    if (st_reg.ctl[irq_pkg::GLOBAL_EN_BIT]) begin
                        st_next.state = irq_pkg::ST_VECTOR;
                    end else begin
                        st_next.state = irq_pkg::ST_ABORT;
                    end
                end
                irq_pkg::ST_VECTOR: begin
                    st_next.state   = irq_pkg::ST_IDLE;
                    st_next.push    = 1'b1;
                    st_next.push_pc = RETURN_PC;
                    st_next.ctl[irq_pkg::GLOBAL_EN_BIT] = 1'b0;
                end
                irq_pkg::ST_ABORT: begin
                    st_next.state = irq_pkg::ST_IDLE;
                end
                default: begin
                    st_next.state = irq_pkg::ST_IDLE;
                end
            endcase
        end

        if (RETURN_FROM_IRQ_INSTR) begin
            st_next.ctl[irq_pkg::GLOBAL_EN_BIT] = 1'b1;
        end

        st_next.nop     = st_next.state != irq_pkg::ST_IDLE;
        st_next.load_pc = irq_pkg::IRQ_VECTOR;

        // Every transfer is answered in the cycle after its setup, so the bus
        // never waits; read data is taken from the registers as they stood then.
        st_next.pready  = apb_setup;
        st_next.pslverr = 1'b0;
        st_next.prdata  = '0;
        if (apb_setup && !PWRITE) begin
            case (PADDR)
                irq_pkg::OFF_CONTROL: st_next.prdata[7:0] = st_reg.ctl;
                irq_pkg::OFF_PFLAG:   st_next.prdata[7:0] = st_reg.pflag;
                irq_pkg::OFF_PEN:     st_next.prdata[7:0] = st_reg.pen;
                irq_pkg::OFF_STATUS:  st_next.prdata[15:0] = flags_view;
                irq_pkg::OFF_CLEAR:   st_next.prdata = '0;
                irq_pkg::OFF_ENABLE:  st_next.prdata[15:0] = en_view;
                default:              st_next.pslverr = 1'b1;
            endcase
        end else if (apb_setup) begin
            case (PADDR)
                irq_pkg::OFF_CONTROL, irq_pkg::OFF_PFLAG, irq_pkg::OFF_PEN,
                irq_pkg::OFF_STATUS, irq_pkg::OFF_CLEAR, irq_pkg::OFF_ENABLE: begin
                    st_next.pslverr = 1'b0;
                end
                default: st_next.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            st_reg         <= '0;
            st_reg.state   <= irq_pkg::ST_IDLE;
            st_reg.ctl     <= irq_pkg::CONTROL_RST;
            st_reg.pflag   <= irq_pkg::PFLAG_RST;
            st_reg.pen     <= irq_pkg::PEN_RST;
            st_reg.load_pc <= irq_pkg::IRQ_VECTOR;
        end else begin
            st_reg <= st_next;
        end
    end

    assign PRDATA            = st_reg.prdata;
    assign PREADY            = st_reg.pready;
    assign PSLVERR           = st_reg.pslverr;
    assign CYCLE_END         = st_reg.cyc_end;
    assign IRQ_REQ           = st_reg.irq_req;
    assign GLOBAL_IRQ_ENABLE = st_reg.ctl[irq_pkg::GLOBAL_EN_BIT];
    assign CORE_NOP          = st_reg.nop;
    assign STACK_PUSH        = st_reg.push;
    assign STACK_PUSH_DATA   = st_reg.push_pc;
    assign PC_LOAD           = st_reg.push;
    assign PC_LOAD_VALUE     = st_reg.load_pc;

    a_gie_after_reset: assert property (
        @(posedge REF_CLK) $fell(RST) |-> !GLOBAL_IRQ_ENABLE
    ) else $error("global enable set after reset");

    a_gie_blocks_entry: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (last && st_reg.state == irq_pkg::ST_IDLE && !GLOBAL_IRQ_ENABLE)
        |=> st_reg.state == irq_pkg::ST_IDLE
    ) else $error("entry started with global enable clear");

    a_mask_blocks_entry: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (last && st_reg.state == irq_pkg::ST_IDLE && !pending)
        |=> st_reg.state == irq_pkg::ST_IDLE
    ) else $error("entry started with no enabled flag");

    a_vector_load: assert property (
        @(posedge REF_CLK) disable iff (RST)
        PC_LOAD |-> (PC_LOAD_VALUE == irq_pkg::IRQ_VECTOR) && STACK_PUSH && $past(last)
    ) else $error("vector load malformed");

    a_accept_clears_gie: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (st_reg.state == irq_pkg::ST_VECTOR && last && !RETURN_FROM_IRQ_INSTR)
        |=> !GLOBAL_IRQ_ENABLE ##0 STACK_PUSH ##0 (STACK_PUSH_DATA == $past(RETURN_PC))
    ) else $error("acceptance did not clear enable and push");

    a_return_sets_gie: assert property (
        @(posedge REF_CLK) disable iff (RST)
        RETURN_FROM_IRQ_INSTR |=> GLOBAL_IRQ_ENABLE
    ) else $error("return did not set global enable");

    a_timer_flag_set: assert property (
        @(posedge REF_CLK) disable iff (RST)
        TIMER_ZERO_OVF |=> st_reg.ctl[irq_pkg::T0_FLAG_BIT]
    ) else $error("timer zero flag not set");

    a_nvm_flag_set: assert property (
        @(posedge REF_CLK) disable iff (RST)
        NVM_EVT |=> st_reg.pflag[irq_pkg::NVM_BIT]
    ) else $error("nonvolatile memory flag not set");

    a_entry_cancel: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (st_reg.state == irq_pkg::ST_FLUSH && last && !GLOBAL_IRQ_ENABLE && !RETURN_FROM_IRQ_INSTR)
        |=> st_reg.state == irq_pkg::ST_ABORT && CORE_NOP && !STACK_PUSH
    ) else $error("cancelled entry not turned into a no-operation");

    a_ext_latency: assert property (
        @(posedge REF_CLK) disable iff (RST)
        ($rose(st_reg.ctl[irq_pkg::EXT_FLAG_BIT]) && st_reg.ctl[irq_pkg::EXT_EN_BIT]
            && GLOBAL_IRQ_ENABLE && st_reg.state == irq_pkg::ST_IDLE)
        ##1 (!PSEL && GLOBAL_IRQ_ENABLE) [*8] |-> ##3 STACK_PUSH
    ) else $error("pin interrupt latency wrong");

    a_gie_gates_request: assert property (
        @(posedge REF_CLK) disable iff (RST)
        !GLOBAL_IRQ_ENABLE |=> !IRQ_REQ
    ) else $error("request raised with global enable clear");

    a_request_raised: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (GLOBAL_IRQ_ENABLE && pending) |=> IRQ_REQ
    ) else $error("request missing for an enabled flag");

    a_push_single: assert property (
        @(posedge REF_CLK) disable iff (RST)
        STACK_PUSH |=> !STACK_PUSH
    ) else $error("push longer than one clock");

    a_cancel_keeps_pending: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (st_reg.state == irq_pkg::ST_FLUSH && last && !GLOBAL_IRQ_ENABLE && !RETURN_FROM_IRQ_INSTR
            && pending && !apb_wr) |=> pending
    ) else $error("cancelled request lost");

    a_ext_flag_set: assert property (
        @(posedge REF_CLK) disable iff (RST)
        ext_rise[0] |=> st_reg.ctl[irq_pkg::EXT_FLAG_BIT]
    ) else $error("pin flag not set");

endmodule

/* rtl/pin_event_sampler.sv */
// Samples pin levels once per instruction cycle and reports rises and changes.
// Assumes pins are already synchronous to clk and sample is a one-cycle pulse.
`timescale 1ns/100ps
module pin_event_sampler #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             sample,
    input  wire logic [WIDTH-1:0] pins,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] change
);

    typedef struct packed {
        logic [WIDTH-1:0] last_pins;
        logic             primed;
    } sampler_state_t;

    sampler_state_t st_reg;
    sampler_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (sample) begin
            st_next.last_pins = pins;
            st_next.primed    = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // The first sample after reset only primes the history, so no false event.
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        assign rise[i]   = sample & st_reg.primed & pins[i] & ~st_reg.last_pins[i];
        assign change[i] = sample & st_reg.primed & (pins[i] ^ st_reg.last_pins[i]);
    end

endmodule

/* tb/core_model.sv */
// Behavioural model of the processor core that faces the interrupt controller.
// Assumes one clock shared with the controller; the bench asks for each return.
`timescale 1ns/100ps
module core_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cycle_end,
    input  wire logic        core_nop,
    input  wire logic        stack_push,
    input  wire logic [12:0] stack_push_data,
    input  wire logic        pc_load,
    input  wire logic [12:0] pc_load_value,
    input  wire logic        ret_req,
    output logic      [12:0] return_pc,
    output logic             return_instr
);
    logic [12:0] stack_reg;

    // The program counter holds while the entry sequence runs, so the pushed
    // address is the one that was current when the request was taken.
    always_ff @(posedge clk) begin
        if (rst) begin
            return_pc <= 13'h0100;
            return_instr <= 1'b0;
            stack_reg <= 13'h0000;
        end else begin
            return_instr <= ret_req;
            if (stack_push) begin
                stack_reg <= stack_push_data;
            end
            if (pc_load) begin
                return_pc <= pc_load_value;
            end else if (return_instr) begin
                return_pc <= stack_reg;
            end else if (cycle_end && !core_nop) begin
                return_pc <= return_pc + 13'h0001;
            end
        end
    end
endmodule

/* tb/mcu_interrupt_controller_bench.sv */
// Self-checking bench of the interrupt controller, registers reached over APB.
// Assumes the core model of tb/core_model.sv and one-cycle APB answers.
`timescale 1ns/100ps
module mcu_interrupt_controller_bench;
    localparam int POS [10] = '{irq_pkg::PB_FLAG_BIT, irq_pkg::EXT_FLAG_BIT, irq_pkg::T0_FLAG_BIT,
        8 + irq_pkg::T1_BIT, 8 + irq_pkg::T2_BIT, 8 + irq_pkg::CMP_BIT, 8 + irq_pkg::TX_BIT,
        8 + irq_pkg::RX_BIT, 8 + irq_pkg::CCP_BIT, 8 + irq_pkg::NVM_BIT};
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, ext_pin, ret_req, ret_instr;
    logic        cyc_end, irq_req, global_irq_enable, core_nop, push, pc_load;
    logic [7:0]  paddr, evt;
    logic [3:0]  pb_nib;
    logic [31:0] pwdata, prdata, d, exp;
    logic [12:0] ret_pc, push_data, load_value;
    int          fails, comparisons, entries, cycles, s, n, e0;

    mcu_interrupt_controller dut (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EXTERNAL_IRQ_PIN(ext_pin), .PORT_B_UPPER_NIBBLE(pb_nib),
        .TIMER_ZERO_OVF(evt[0]), .TIMER_ONE_OVF(evt[1]), .TIMER_TWO_MATCH(evt[2]), .CMP_EVT(evt[3]),
        .TX_EVT(evt[4]), .RX_EVT(evt[5]), .CCP_EVT(evt[6]), .NVM_EVT(evt[7]),
        .RETURN_FROM_IRQ_INSTR(ret_instr), .RETURN_PC(ret_pc), .CYCLE_END(cyc_end), .IRQ_REQ(irq_req),
        .GLOBAL_IRQ_ENABLE(global_irq_enable), .CORE_NOP(core_nop), .STACK_PUSH(push), .STACK_PUSH_DATA(push_data),
        .PC_LOAD(pc_load), .PC_LOAD_VALUE(load_value));

    core_model partner (.clk(clk), .rst(rst), .cycle_end(cyc_end), .core_nop(core_nop),
        .stack_push(push), .stack_push_data(push_data), .pc_load(pc_load),
        .pc_load_value(load_value), .ret_req(ret_req), .return_pc(ret_pc), .return_instr(ret_instr));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic close_out();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] got);
        comparisons++;
        if (got !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic e, input logic got);
        comparisons++;
        if (got !== e) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", what, e, got);
        end
    endtask

    function automatic logic mapped(input logic [7:0] a);
        return a inside {irq_pkg::OFF_CONTROL, irq_pkg::OFF_PFLAG, irq_pkg::OFF_PEN,
                         irq_pkg::OFF_STATUS, irq_pkg::OFF_CLEAR, irq_pkg::OFF_ENABLE};
    endfunction

    // Every driving task starts at a fresh edge, so no signal is assigned twice in one step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] e);
        logic [31:0] r;
        logic        err;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk_bit("slave error", !mapped(a), err);
        if (!w) chk_word($sformatf("read %h", a), e, r);
    endtask

    task automatic wait_clks(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic trigger(input int src);
        @(posedge clk);
        if (src == 0) pb_nib <= pb_nib ^ 4'(($urandom % 15) + 1);
        else if (src == 1) ext_pin <= 1'b1;
        else evt[src-2] <= 1'b1;
        @(posedge clk);
        evt <= 8'h00;
    endtask

    task automatic wait_entry(input int target);
        n = 0;
        while (entries < target && n < 40) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic ret_pulse();
        @(posedge clk);
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        wait_clks(3);
    endtask

    always @(negedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            close_out();
        end
        if (!rst && push) begin
            entries++;
            chk_bit("load with push", 1'b1, pc_load);
            chk_word("vector", 32'h0000_0004, {19'h0_0000, load_value});
            chk_word("pushed pc", {19'h0_0000, ret_pc}, {19'h0_0000, push_data});
            chk_bit("global at entry", 1'b0, global_irq_enable);
            chk_bit("cycle end at push", 1'b0, cyc_end);
        end
    end

    initial begin
        {rst, psel, penable, pwrite, ext_pin, ret_req} = 6'b10_0000;
        {paddr, evt, pb_nib, pwdata} = '0;
        {fails, comparisons, entries, cycles} = '0;
        void'($urandom(32'h7253_abf1));
        wait_clks(3);
        rst <= 1'b0;
        @(negedge clk);
        chk_bit("global after reset", 1'b0, global_irq_enable);
        apb(1'b0, irq_pkg::OFF_CONTROL, 0, 32'h0000_0000);
        apb(1'b0, irq_pkg::OFF_PFLAG, 0, 32'h0000_0000);
        apb(1'b0, irq_pkg::OFF_PEN, 0, 32'h0000_0000);
        apb(1'b1, irq_pkg::OFF_STATUS, 32'hFFFF_FFFF, 0);
        apb(1'b0, irq_pkg::OFF_STATUS, 0, 32'h0000_0000);
        apb(1'b0, 8'h18, 0, 32'h0000_0000);
        $display("test reset done");
        repeat (4) begin
            d = $urandom;
            apb(1'b1, irq_pkg::OFF_ENABLE, d, 0);
            apb(1'b0, irq_pkg::OFF_ENABLE, 0, d & {16'h0000, irq_pkg::PERIPH_MASK, 8'h07});
            apb(1'b0, irq_pkg::OFF_PEN, 0, {24'h00_0000, d[15:8] & irq_pkg::PERIPH_MASK});
            apb(1'b0, irq_pkg::OFF_CONTROL, 0, {26'h000_0000, d[2:0], 3'h0});
        end
        $display("test enables done");
        apb(1'b1, irq_pkg::OFF_ENABLE, 0, 0);
        apb(1'b1, irq_pkg::OFF_CONTROL, 32'h0000_0080, 0);
        exp = '0;
        for (s = 0; s < 10; s++) begin
            trigger(s);
            wait_clks(8);
            exp[POS[s]] = 1'b1;
            apb(1'b0, irq_pkg::OFF_STATUS, 0, exp);
        end
        ext_pin <= 1'b0;
        @(negedge clk);
        chk_word("entries while masked", 0, entries);
        chk_bit("request while masked", 1'b0, irq_req);
        apb(1'b1, irq_pkg::OFF_CLEAR, 32'h0000_FFFF, 0);
        apb(1'b0, irq_pkg::OFF_STATUS, 0, 32'h0000_0000);
        $display("test flags done");
        for (s = 0; s < 10; s++) begin
            apb(1'b1, irq_pkg::OFF_CONTROL, 32'h0000_0080, 0);
            apb(1'b1, irq_pkg::OFF_ENABLE, 32'h1 << POS[s], 0);
            e0 = entries;
            wait_clks($urandom_range(0, 3));
            trigger(s);
            wait_entry(e0 + 1);
            chk_word("entry count", e0 + 1, entries);
            if (s < 2) chk_bit("latency in range", 1'b1, n >= 12 && n <= 16);
            apb(1'b0, irq_pkg::OFF_STATUS, 0, 32'h1 << POS[s]);
            apb(1'b1, irq_pkg::OFF_CLEAR, 32'h0000_FFFF, 0);
            ret_pulse();
            @(negedge clk);
            chk_bit("global after return", 1'b1, global_irq_enable);
            wait_clks(30);
            chk_word("no repeat entry", e0 + 1, entries);
            ext_pin <= 1'b0;
        end
        $display("test entry done");
        apb(1'b1, irq_pkg::OFF_CONTROL, 32'h0000_0080, 0);
        apb(1'b1, irq_pkg::OFF_ENABLE, 32'h1 << POS[3], 0);
        e0 = entries;
        trigger(3);
        n = 0;
        while (core_nop !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk_bit("nop before cancel", 1'b1, core_nop);
        apb(1'b1, irq_pkg::OFF_CONTROL, 32'h0000_0000, 0);
        wait_clks(24);
        @(negedge clk);
        chk_word("entries after cancel", e0, entries);
        chk_bit("request after cancel", 1'b0, irq_req);
        apb(1'b0, irq_pkg::OFF_STATUS, 0, 32'h1 << POS[3]);
        apb(1'b1, irq_pkg::OFF_CONTROL, 32'h0000_0080, 0);
        wait_clks(2);
        @(negedge clk);
        chk_bit("request when enabled", 1'b1, irq_req);
        wait_entry(e0 + 1);
        chk_word("entries after re-enable", e0 + 1, entries);
        ret_pulse();
        wait_entry(e0 + 2);
        chk_word("re-entry without clear", e0 + 2, entries);
        apb(1'b1, irq_pkg::OFF_CLEAR, 32'h0000_FFFF, 0);
        ret_pulse();
        $display("test cancel done");
        close_out();
    end
endmodule
